// file: tb/ssu_eu_model.sv
// Execution unit model supplying segment bases and offsets
`timescale 1ns/100ps
module ssu_eu_model (
  input  wire        ref_clk,
  input  wire        upd,
  input  wire [31:0] rnd,
  output reg  [95:0] st
);
  // New values enter only between requests, so a taken request sees stable bases
  initial st = 96'h0;
  always @(posedge ref_clk) if (upd) st <= {st[63:0], rnd};
endmodule

// file: tb/ssu_segment_select_monitor.sv
// Checker for segment choice and handshake of the segment select unit
`timescale 1ns/100ps
module ssu_segment_select_monitor (
  input wire        ref_clk, reset, clk_en, ref_valid, ref_ready, addr_valid,
  input wire        override_valid, stack_push,
  input wire [2:0]  ref_kind,
  input wire [1:0]  override_seg, seg_used,
  input wire [15:0] instruction_pointer, offset_used, stack_top_offset,
  input wire [19:0] phys_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A request accepted by the unit
  sequence take;
    clk_en && ref_valid && ref_ready;
  endsequence
  a_answer_next: assert property (take |=> addr_valid && !ref_ready)
    else $error("no answer");
  a_fetch_code: assert property (take ##0 ref_kind == 3'h0 |=> seg_used == 2'h1 &&
    offset_used == $past(instruction_pointer)) else $error("bad fetch");
  a_stack_seg: assert property (take ##0 ref_kind == 3'h1 |=> seg_used == 2'h2)
    else $error("bad stack");
  a_push_first: assert property (take ##0 (ref_kind == 3'h1 && stack_push) |=>
    offset_used == $past(stack_top_offset) - 16'h2) else $error("bad push");
  a_var_data: assert property (take ##0 (ref_kind == 3'h2 && !override_valid) |=>
    seg_used == 2'h3) else $error("bad var");
  a_bp_stack: assert property (take ##0 (ref_kind == 3'h5 && !override_valid) |=>
    seg_used == 2'h2) else $error("bad bp");
  a_dst_extra: assert property (take ##0 ref_kind == 3'h4 |=> seg_used == 2'h0)
    else $error("bad dst");
  a_src_data: assert property (take ##0 (ref_kind == 3'h3 && !override_valid) |=>
    seg_used == 2'h3) else $error("bad src");
  a_freeze_hold: assert property (!clk_en |=> $stable(addr_valid) &&
    $stable(phys_addr) && $stable(stack_top_offset)) else $error("stall moved state");
  a_override_used: assert property (take ##0 (override_valid &&
    ref_kind inside {3'h2, 3'h3, 3'h5}) |=> seg_used == $past(override_seg)) else $error("bad ovr");
endmodule

// file: tb/ssu_segment_select_tb.sv
// Self-checking bench for the segment select unit
`timescale 1ns/100ps
module ssu_segment_select_tb;
  reg ref_clk = 0, reset = 1, ref_valid = 0, upd = 0, ovr = 0, push = 0, wrd = 0, dn = 0, ld = 0;
  reg ce = 1;
  reg [2:0] kind = 0;
  reg [1:0] oseg = 0, sg;
  reg [31:0] r = 32'h90ff0c6c;
  reg [15:0] si, di, sp, off, stp;
  reg [37:0] q[$];
  integer n_errors = 0, tests_run = 0, i;
  wire [95:0] st;
  wire av, rdy;
  wire [19:0] pa;
  wire [1:0] su;
  wire [15:0] ou, so, dso, spo;
  always #5 ref_clk = ~ref_clk;
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [15:0] base(input [1:0] s);
    base = s == 0 ? st[47:32] : s == 1 ? st[15:0] : s == 2 ? st[63:48] : st[31:16];
  endfunction
  task check(input [47:0] s, e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value t=%0t seen %h exp %h", $time, s, e);
    end
  end endtask
  task results; begin
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  ssu_segment_select i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(ce),
    .code_segment_base(st[15:0]), .data_segment_base(st[31:16]), .extra_segment_base(st[47:32]),
    .stack_segment_base(st[63:48]), .instruction_pointer(st[79:64]), .effective_address(st[95:80]),
    .index_load(ld), .source_index_in(r[15:0]), .destination_index_in(r[31:16]), .stack_load(ld),
    .stack_top_in(r[23:8]), .ref_valid(ref_valid), .ref_kind(kind), .override_valid(ovr),
    .override_seg(oseg), .stack_push(push), .str_word(wrd), .str_down(dn), .ref_ready(rdy),
    .addr_valid(av), .phys_addr(pa), .seg_used(su), .offset_used(ou), .source_index(so),
    .destination_index(dso), .stack_top_offset(spo));
  ssu_eu_model i_eu (.ref_clk(ref_clk), .upd(upd), .rnd(r), .st(st));
  // Each answer pulse consumes the oldest expectation; negedge keeps it race free
  always @(negedge ref_clk) if (av === 1'b1) begin
    if (q.size() == 0) check(1, 0);
    else check({pa, su, ou}, q.pop_front());
  end
  // One random request, spaced so the unit is never asked back to back
  task req; begin
    @(posedge ref_clk); #1 r = lfsr(r); upd = 1;
    @(posedge ref_clk); #1 upd = 0; r = lfsr(r);
    kind = r[2:0] % 6; ovr = r[3]; oseg = r[5:4]; push = r[6]; wrd = r[7]; dn = r[8];
    stp = wrd ? 16'h2 : 16'h1;
    case (kind)
      0: begin sg = 1; off = st[79:64]; end
      1: begin sg = 2; off = push ? sp - 16'h2 : sp; sp = push ? sp - 16'h2 : sp + 16'h2; end
      3: begin sg = ovr ? oseg : 2'h3; off = si; si = dn ? si - stp : si + stp; end
      4: begin sg = 0; off = di; di = dn ? di - stp : di + stp; end
      5: begin sg = ovr ? oseg : 2'h2; off = st[95:80]; end
      default: begin sg = ovr ? oseg : 2'h3; off = st[95:80]; end
    endcase
    q.push_back({{base(sg), 4'h0} + {4'h0, off}, sg, off});
    ref_valid = 1; ce = ~r[9];
    // A stalled edge must not take the request; it is taken one edge later
    if (!ce) begin @(posedge ref_clk); #1 check({av, rdy}, 1); ce = 1; end
    @(posedge ref_clk); #1 ref_valid = 0;
    @(posedge ref_clk); #1 check({so, dso, spo}, {si, di, sp});
  end endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    check({av, rdy}, 1);
    check({pa, su, ou}, {20'h0, 2'h3, 16'h0});
    #1 reset = 0; ld = 1; si = r[15:0]; di = r[31:16]; sp = r[23:8];
    @(posedge ref_clk); #1 ld = 0;
    for (i = 0; i < 200; i = i + 1) req;
    check(q.size(), 0);
    results;
  end
  // Watchdog well beyond the 1000 or so cycles the sequence needs, stalls included
  initial begin #20000; check(1, 0); results; end
endmodule
bind ssu_segment_select ssu_segment_select_monitor i_mon (.*);

// file: verilog/ssu_defines.vh
// Constants for the segment select unit
`ifndef SSU_DEFINES_VH
`define SSU_DEFINES_VH
// Reference kinds, 3-bit code
`define SSU_REF_FETCH   3'h0
`define SSU_REF_STACK   3'h1
`define SSU_REF_VAR     3'h2
`define SSU_REF_STR_SRC 3'h3
`define SSU_REF_STR_DST 3'h4
`define SSU_REF_BP      3'h5
// Segment select codes
`define SSU_SEG_EXTRA   2'h0
`define SSU_SEG_CODE    2'h1
`define SSU_SEG_STACK   2'h2
`define SSU_SEG_DATA    2'h3
// Address forming
`define SSU_SEG_SHIFT   4
`define SSU_STACK_STEP  16'h0002
`define SSU_BYTE_STEP   16'h0001
`define SSU_WORD_STEP   16'h0002
`define SSU_ZERO16      16'h0000
`define SSU_ZERO20      20'h00000
`define SSU_ZERO4       4'h0
`define SSU_ZERO32      32'h00000000
// Overrides honoured per kind, one bit per segment code
`define SSU_OVR_NONE    4'h0
`define SSU_OVR_VAR     4'h7
`define SSU_OVR_BP      4'hb
`define SSU_OVR_ANY     4'hf
// String index entries, packed side by side
`define SSU_IDX_NUM     2
`define SSU_IDX_W       16
`define SSU_SRC_LSB     0
`define SSU_DST_LSB     16
// State codes, one-hot
`define SSU_ST_IDLE     2'h1
`define SSU_ST_BUSY     2'h2
`endif

// file: verilog/ssu_segment_select.v
// Segment select and physical address forming for a segmented bus interface
`timescale 1ns/100ps
`include "ssu_defines.vh"

module ssu_segment_select (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clk_en,
  // Segment bases from the execution unit
  input  wire [15:0] code_segment_base,
  input  wire [15:0] data_segment_base,
  input  wire [15:0] extra_segment_base,
  input  wire [15:0] stack_segment_base,
  // Offset sources
  input  wire [15:0] instruction_pointer,
  input  wire [15:0] effective_address,
  // Index and stack loads
  input  wire        index_load,
  input  wire [15:0] source_index_in,
  input  wire [15:0] destination_index_in,
  input  wire        stack_load,
  input  wire [15:0] stack_top_in,
  // Reference request
  input  wire        ref_valid,
  input  wire [2:0]  ref_kind,
  input  wire        override_valid,
  input  wire [1:0]  override_seg,
  input  wire        stack_push,
  input  wire        str_word,
  input  wire        str_down,
  // Result
  output wire        ref_ready,
  output reg         addr_valid,
  output reg  [19:0] phys_addr,
  output reg  [1:0]  seg_used,
  output reg  [15:0] offset_used,
  output wire [15:0] source_index,
  output wire [15:0] destination_index,
  output wire [15:0] stack_top_offset
);

  // State codes, one-hot
  localparam ST_IDLE = `SSU_ST_IDLE;
  localparam ST_BUSY = `SSU_ST_BUSY;

  // Handshake state
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  wire        take;

  // Next values of the result registers
  reg         addr_valid_nxt;
  reg  [19:0] phys_addr_nxt;
  reg  [1:0]  seg_used_nxt;
  reg  [15:0] offset_used_nxt;

  // String index entries, source in the low half
  reg  [31:0] idx_r;
  wire [31:0] idx_nxt;
  wire [31:0] idx_load_bus;
  wire [1:0]  idx_hit;
  wire [15:0] str_step;
  genvar      g;

  // Stack top
  reg  [15:0] sp_r;
  reg  [15:0] sp_nxt;
  wire [15:0] sp_dec;
  wire [15:0] sp_inc;

  // Reference decode
  wire        kind_stack;
  wire        kind_str_src;
  wire        kind_str_dst;
  reg  [1:0]  seg_dflt;
  reg  [3:0]  ovr_mask;
  wire        ovr_ok;
  wire [1:0]  seg_sel;
  reg  [15:0] off_sel;

  // Address forming
  reg  [15:0] seg_base;
  wire [19:0] base_shifted;
  wire [19:0] off_wide;
  wire [19:0] addr_sum;

  // Level outputs straight from the registers
  assign source_index      = idx_r[`SSU_SRC_LSB +: `SSU_IDX_W];
  assign destination_index = idx_r[`SSU_DST_LSB +: `SSU_IDX_W];
  assign stack_top_offset  = sp_r;

  // One request every other cycle; the result register frees next cycle
  assign ref_ready = (state_r == ST_IDLE);
  assign take      = ref_valid && ref_ready;

  // Only these kinds move the index or stack registers
  assign kind_stack   = (ref_kind == `SSU_REF_STACK);
  assign kind_str_src = (ref_kind == `SSU_REF_STR_SRC);
  assign kind_str_dst = (ref_kind == `SSU_REF_STR_DST);

  // Default segment and the overrides each kind honours
  always @* begin
    seg_dflt = `SSU_SEG_DATA;
    ovr_mask = `SSU_OVR_NONE;
    case (ref_kind)
      `SSU_REF_FETCH: begin
        seg_dflt = `SSU_SEG_CODE;
        ovr_mask = `SSU_OVR_NONE;
      end
      `SSU_REF_STACK: begin
        seg_dflt = `SSU_SEG_STACK;
        ovr_mask = `SSU_OVR_NONE;
      end
      `SSU_REF_VAR: begin
        seg_dflt = `SSU_SEG_DATA;
        ovr_mask = `SSU_OVR_VAR;
      end
      `SSU_REF_STR_SRC: begin
        seg_dflt = `SSU_SEG_DATA;
        ovr_mask = `SSU_OVR_ANY;
      end
      `SSU_REF_STR_DST: begin
        seg_dflt = `SSU_SEG_EXTRA;
        ovr_mask = `SSU_OVR_NONE;
      end
      `SSU_REF_BP: begin
        seg_dflt = `SSU_SEG_STACK;
        ovr_mask = `SSU_OVR_BP;
      end
      default: begin
        // Unknown kinds act as plain variables without override
        seg_dflt = `SSU_SEG_DATA;
        ovr_mask = `SSU_OVR_NONE;
      end
    endcase
  end

  // A prefix naming a segment the kind does not allow leaves the default
  assign ovr_ok  = override_valid && ovr_mask[override_seg];
  assign seg_sel = ovr_ok ? override_seg : seg_dflt;

  // Offset source per kind
  always @* begin
    off_sel = effective_address;
    case (ref_kind)
      `SSU_REF_FETCH: begin
        off_sel = instruction_pointer;
      end
      `SSU_REF_STACK: begin
        // Push uses the already lowered pointer as its address
        off_sel = stack_push ? sp_dec : sp_r;
      end
      `SSU_REF_STR_SRC: begin
        off_sel = source_index;
      end
      `SSU_REF_STR_DST: begin
        off_sel = destination_index;
      end
      default: begin
        off_sel = effective_address;
      end
    endcase
  end

  // Base register lookup
  always @* begin
    case (seg_sel)
      `SSU_SEG_CODE: begin
        seg_base = code_segment_base;
      end
      `SSU_SEG_STACK: begin
        seg_base = stack_segment_base;
      end
      `SSU_SEG_DATA: begin
        seg_base = data_segment_base;
      end
      default: begin
        // Extra segment doubles as the fallback
        seg_base = extra_segment_base;
      end
    endcase
  end

  // Base shifted up by four bits, offset zero-extended to the bus width
  assign base_shifted = {`SSU_ZERO4, seg_base} << `SSU_SEG_SHIFT;
  assign off_wide     = {`SSU_ZERO4, off_sel};
  // Wraps at 1 MiB, as a 20-bit bus does
  assign addr_sum     = base_shifted + off_wide;

  // Handshake state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ref_valid) begin
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Result capture; the address stands until the next accepted request
  always @* begin
    addr_valid_nxt  = take;
    phys_addr_nxt   = phys_addr;
    seg_used_nxt    = seg_used;
    offset_used_nxt = offset_used;
    if (take) begin
      phys_addr_nxt   = addr_sum;
      seg_used_nxt    = seg_sel;
      offset_used_nxt = off_sel;
    end
  end

  // Index load values and step requests, source entry first
  assign idx_load_bus = {destination_index_in, source_index_in};
  assign idx_hit      = {kind_str_dst, kind_str_src};
  assign str_step     = str_word ? `SSU_WORD_STEP : `SSU_BYTE_STEP;

  // One copy of the step logic per string index
  generate
    for (g = 0; g < `SSU_IDX_NUM; g = g + 1) begin : g_idx
      wire [15:0] cur;
      wire [15:0] stepped;
      wire [15:0] loaded;
      assign cur     = idx_r[g*`SSU_IDX_W +: `SSU_IDX_W];
      assign loaded  = idx_load_bus[g*`SSU_IDX_W +: `SSU_IDX_W];
      // Direction comes from the execution unit's direction flag
      assign stepped = str_down ? cur - str_step : cur + str_step;
      // Loads win over the automatic step so software can reposition
      assign idx_nxt[g*`SSU_IDX_W +: `SSU_IDX_W] = index_load ? loaded :
                                                   (take && idx_hit[g]) ? stepped : cur;
    end
  endgenerate

  // Pointer moves; a push addresses the lowered value, a pop the old one
  assign sp_dec = sp_r - `SSU_STACK_STEP;
  assign sp_inc = sp_r + `SSU_STACK_STEP;

  // Stack top: a load wins, else each accepted stack reference moves it a word
  always @* begin
    sp_nxt = sp_r;
    if (stack_load) begin
      sp_nxt = stack_top_in;
    end else if (take && kind_stack) begin
      sp_nxt = stack_push ? sp_dec : sp_inc;
    end
  end

  // Handshake state register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Answer pulse; clk_en low stretches it, so stall only between requests
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_valid <= 1'b0;
    end else if (clk_en) begin
      addr_valid <= addr_valid_nxt;
    end
  end

  // Held result registers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phys_addr   <= `SSU_ZERO20;
      seg_used    <= `SSU_SEG_DATA;
      offset_used <= `SSU_ZERO16;
    end else if (clk_en) begin
      phys_addr   <= phys_addr_nxt;
      seg_used    <= seg_used_nxt;
      offset_used <= offset_used_nxt;
    end
  end

  // Index registers
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idx_r <= `SSU_ZERO32;
    end else if (clk_en) begin
      idx_r <= idx_nxt;
    end
  end

  // Stack top register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sp_r <= `SSU_ZERO16;
    end else if (clk_en) begin
      sp_r <= sp_nxt;
    end
  end

endmodule
